/* hw/isc_pkg.sv */
package isc_pkg;
  // Clock rate and tick
  localparam int CLK_HZ = 100_000_000;
  localparam int PWM_HZ = 80; // Valve drive frequency
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ; // 1250000 cycles
  // Duty in half-percent units: 0..200
  localparam int DUTY_W = 8;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 8'h00_C8;
  // Table geometry: seven breakpoints, -150..+150 in 50 rpm steps
  localparam int TBL_N = 7;
  localparam int ERR_STEP_RPM = 50;
  localparam int ERR_SPAN_RPM = 150;
  localparam int FUEL_N = 5;
  localparam logic [15:0] TARGET_STEP_RPM = 16'h0032;
  localparam logic [15:0] FUEL_UNITY = 16'h0064; // 100 percent
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_FAST_TARGET = 8'h08;
  localparam logic [7:0] REG_DECAY_TICKS = 8'h0C;
  localparam logic [7:0] REG_VALVE_CFG = 8'h10;
  localparam logic [7:0] REG_VALVE_TICKS = 8'h14;
  localparam logic [7:0] REG_SPARK_CFG = 8'h18;
  localparam logic [7:0] REG_SPARK_TICKS = 8'h1C;
  localparam logic [7:0] REG_VALVE_TBL = 8'h20; // 7 words
  localparam logic [7:0] REG_SPARK_TBL = 8'h40; // 7 words
  localparam logic [7:0] REG_FUEL_DUTY = 8'h60; // 5 words
  localparam logic [7:0] REG_FUEL_CORR = 8'h80; // 5 words
  localparam logic [7:0] REG_STATUS = 8'hA0;
  localparam logic [7:0] REG_OUTPUTS = 8'hA4;
  // Control bit positions
  localparam int CTRL_VALVE_EN = 0;
  localparam int CTRL_SPARK_EN = 1;
  // Check interval tick: one tick per 10 ms
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // Reset values of the settings
  localparam logic [15:0] RST_TARGET = 16'h03E8; // 1000 rpm
  localparam logic [15:0] RST_FAST_TARGET = 16'h0514; // 1300 rpm
  localparam logic [15:0] RST_DECAY_TICKS = 16'h0019; // Base ticks per decay step
  localparam logic [7:0] RST_VALVE_MAX = 8'h06; // Half percent
  localparam logic [7:0] RST_VALVE_MIN = 8'h4E; // Half percent
  localparam logic [15:0] RST_VALVE_TICKS = 16'h0055;
  localparam logic [7:0] RST_SPARK_MAX = 8'h08; // Degrees
  localparam logic [15:0] RST_SPARK_TICKS = 16'h0019;
  localparam int RST_FUEL_DUTY0 = 60; // First fuel breakpoint, half percent
  localparam int RST_FUEL_DUTY_STEP = 20; // Spacing of the default breakpoints
  localparam int PWM_MIN_CYC = 200; // One PWM count per half percent at least

  // Engine condition bundle
  typedef struct packed {
    logic [15:0] rpm;
    logic throttle_ok;
    logic speed_ok;
    logic coolant_ok;
    logic [DUTY_W-1:0] warm_duty;
  } isc_engine_s;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } isc_bus_s;
endpackage : isc_pkg

/* hw/isc_top.sv */
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ns
// Behaviour
// - Valve trim runs only when enabled
// - Valve adjustment clamped to plus/minus limit
// - Valve correction updates once per interval
// - Final duty never below minimum duty while valve trim runs
// - Valve table indexed by error, -150..+150
// - Positive when slow, negative when fast
// - Valve entries in half-percent steps
// - Spark trim has its own enable
// - Spark adjustment clamped to plus/minus degrees
// - Spark updated once per own interval
// - Spark table by error, retard when fast
// - Fuel scale looked up from valve duty
// - Fuel table 100 percent means unchanged
// - Enabling conditions gate all trimming
// - Target decays 50 rpm per interval
// - Valve drive is 80 Hz low-side PWM
module isc_top
  import isc_pkg::*;
#(
  parameter int PWM_CYC = PWM_PERIOD_CYC,
  parameter int TICK_LEN = TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire isc_pkg::isc_engine_s engine,
  input wire isc_pkg::isc_bus_s bus,
  output logic [31:0] rdata,
  output logic valve_low_n,
  output logic [DUTY_W-1:0] valve_duty,
  output logic signed [7:0] spark_corr,
  output logic [15:0] fuel_scale
);
  import isc_pkg::*;

  // Refuse settings that the logic cannot serve: the PWM needs one count per half percent,
  // and a tick of zero length would never fire
  if (PWM_CYC < PWM_MIN_CYC || TICK_LEN < 1) begin : g_bad_timing
    $error("isc_top: bad timing parameters");
  end

  // Reset synchroniser
  // Only the second flop feeds the design; the first may settle late on release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Configuration registers
  logic [1:0] ctrl;
  logic [15:0] target;
  logic [15:0] fast_target;
  logic [15:0] decay_ticks;
  logic [7:0] valve_max; // Authority, half percent
  logic [7:0] valve_min; // Floor, half percent
  logic [15:0] valve_ticks;
  logic [7:0] spark_max; // Authority, degrees
  logic [15:0] spark_ticks;
  logic signed [7:0] valve_tbl [TBL_N];
  logic signed [7:0] spark_tbl [TBL_N];
  logic [7:0] fuel_duty [FUEL_N];
  logic [15:0] fuel_corr [FUEL_N];

  // Address decode
  wire wr_ctrl = bus.wr && bus.addr == REG_CTRL;
  wire wr_tgt = bus.wr && bus.addr == REG_TARGET;
  wire wr_fast = bus.wr && bus.addr == REG_FAST_TARGET;
  wire wr_decay = bus.wr && bus.addr == REG_DECAY_TICKS;
  wire wr_vcfg = bus.wr && bus.addr == REG_VALVE_CFG;
  wire wr_vtk = bus.wr && bus.addr == REG_VALVE_TICKS;
  wire wr_scfg = bus.wr && bus.addr == REG_SPARK_CFG;
  wire wr_stk = bus.wr && bus.addr == REG_SPARK_TICKS;

  // Scalar register writes
  // Settings may change at any time; a new authority limit takes hold at the next check, a new floor at once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 2'b00;
      target <= RST_TARGET;
      fast_target <= RST_FAST_TARGET;
      decay_ticks <= RST_DECAY_TICKS;
      valve_max <= RST_VALVE_MAX;
      valve_min <= RST_VALVE_MIN;
      valve_ticks <= RST_VALVE_TICKS;
      spark_max <= RST_SPARK_MAX;
      spark_ticks <= RST_SPARK_TICKS;
    end else if (clk_en) begin
      if (wr_ctrl) ctrl <= bus.wdata[1:0];
      if (wr_tgt) target <= bus.wdata[15:0];
      if (wr_fast) fast_target <= bus.wdata[15:0];
      if (wr_decay) decay_ticks <= bus.wdata[15:0];
      if (wr_vcfg) begin
        valve_max <= bus.wdata[7:0];
        valve_min <= bus.wdata[15:8];
      end
      if (wr_vtk) valve_ticks <= bus.wdata[15:0];
      if (wr_scfg) spark_max <= bus.wdata[7:0];
      if (wr_stk) spark_ticks <= bus.wdata[15:0];
    end
  end

  // Table storage, one word per entry
  // Valve and spark entries are signed bytes; the upper bits of a write are ignored
  for (genvar g = 0; g < TBL_N; g++) begin : g_tbl
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        valve_tbl[g] <= 8'sh00;
        spark_tbl[g] <= 8'sh00;
      end else if (clk_en && bus.wr) begin
        if (bus.addr == REG_VALVE_TBL + 8'(4 * g)) valve_tbl[g] <= bus.wdata[7:0];
        if (bus.addr == REG_SPARK_TBL + 8'(4 * g)) spark_tbl[g] <= bus.wdata[7:0];
      end
    end
  end
  for (genvar g = 0; g < FUEL_N; g++) begin : g_fuel
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        fuel_duty[g] <= 8'(RST_FUEL_DUTY0 + RST_FUEL_DUTY_STEP * g);
        fuel_corr[g] <= FUEL_UNITY; // Neutral until programmed
      end else if (clk_en && bus.wr) begin
        if (bus.addr == REG_FUEL_DUTY + 8'(4 * g)) fuel_duty[g] <= bus.wdata[7:0];
        if (bus.addr == REG_FUEL_CORR + 8'(4 * g)) fuel_corr[g] <= bus.wdata[15:0];
      end
    end
  end

  // Base interval tick
  // Every check interval counts these ticks, so one counter serves all of them
  logic [31:0] tick_cnt;
  wire tick = tick_cnt == 32'(TICK_LEN - 1);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) tick_cnt <= 32'h0000_0000;
    else if (clk_en) tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
  end

  // Enabling conditions
  // Losing any one condition drops both trims back to open loop at once
  wire active = engine.throttle_ok && engine.speed_ok && engine.coolant_ok;

  // Effective target: starts at fast target on entry, steps down
  logic [15:0] eff_target;
  logic [15:0] decay_cnt;
  logic active_d;
  wire decay_due = tick && decay_cnt + 16'h0001 >= decay_ticks;
  wire [15:0] stepped = eff_target - TARGET_STEP_RPM;
  wire [15:0] next_target = (eff_target <= target + TARGET_STEP_RPM) ? target : stepped;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eff_target <= RST_TARGET;
      decay_cnt <= 16'h0000;
      active_d <= 1'b0;
    end else if (clk_en) begin
      active_d <= active;
      if (active && !active_d) begin
        eff_target <= fast_target;
        decay_cnt <= 16'h0000;
      end else if (!active) begin
        eff_target <= target;
      end else if (decay_due) begin
        decay_cnt <= 16'h0000;
        eff_target <= next_target;
      end else if (tick) begin
        decay_cnt <= decay_cnt + 16'h0001;
      end
    end
  end

  // Speed error and table index, clipped to the end entries
  wire signed [17:0] err = $signed({2'b00, engine.rpm}) - $signed({2'b00, eff_target});
  // An error halfway between two breakpoints takes the higher one
  function automatic logic [2:0] err_index(input logic signed [17:0] e);
    logic signed [17:0] q;
    q = (e + 18'sd25 + 18'sd150) / 18'sd50; // Round to nearest breakpoint
    if (e <= -18'sd150) return 3'd0;
    if (e >= 18'sd150) return 3'd6;
    return q[2:0];
  endfunction
  wire [2:0] idx = err_index(err);
  // Tables hold positive-when-slow entries; error is rpm minus target
  wire signed [7:0] valve_step = valve_tbl[idx];
  wire signed [7:0] spark_step = spark_tbl[idx];

  // Valve and spark interval counters
  // Separate counters keep the two check intervals independent of each other
  logic [15:0] vcnt;
  logic [15:0] scnt;
  wire vdue = tick && vcnt + 16'h0001 >= valve_ticks;
  wire sdue = tick && scnt + 16'h0001 >= spark_ticks;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcnt <= 16'h0000;
      scnt <= 16'h0000;
    end else if (clk_en && tick) begin
      vcnt <= vdue ? 16'h0000 : vcnt + 16'h0001;
      scnt <= sdue ? 16'h0000 : scnt + 16'h0001;
    end
  end

  // Accumulators with authority clamp
  // Clamping the running sum, not the step, lets the trim rest at its limit without winding up
  function automatic logic signed [9:0] clamp(input logic signed [9:0] v, input logic [7:0] lim);
    logic signed [9:0] l;
    l = $signed({2'b00, lim});
    if (v > l) return l;
    if (v < -l) return -l;
    return v;
  endfunction
  logic signed [9:0] vacc;
  logic signed [9:0] sacc;
  // Each trim needs its own enable as well as every enabling condition
  wire valve_on = ctrl[CTRL_VALVE_EN] && active;
  wire spark_on = ctrl[CTRL_SPARK_EN] && active;
  wire signed [9:0] next_vacc = clamp(vacc + 10'(valve_step), valve_max);
  wire signed [9:0] next_sacc = clamp(sacc + 10'(spark_step), spark_max);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vacc <= 10'sd0;
      sacc <= 10'sd0;
    end else if (clk_en) begin
      if (!valve_on) vacc <= 10'sd0;
      else if (vdue) vacc <= next_vacc;
      if (!spark_on) sacc <= 10'sd0;
      else if (sdue) sacc <= next_sacc;
    end
  end

  // Final duty: warmup plus trim, floored, capped at full
  // The floor binds only while trimming; in open loop the warmup duty passes untouched
  wire signed [10:0] raw = $signed({3'b000, engine.warm_duty}) + 11'(vacc);
  wire signed [10:0] floor_d = valve_on && raw < $signed({3'b000, valve_min}) ? $signed({3'b000, valve_min}) : raw;
  wire [DUTY_W-1:0] next_duty = floor_d < 0 ? '0 : (floor_d > $signed({3'b000, DUTY_FULL}) ? DUTY_FULL :
    floor_d[DUTY_W-1:0]);

  // Fuel scale from duty: nearest breakpoint at or below duty
  // Below the first breakpoint the first correction still applies; there is no interpolation
  logic [15:0] next_fuel;
  always_comb begin
    next_fuel = fuel_corr[0];
    for (int i = 1; i < FUEL_N; i++) begin
      if (next_duty >= fuel_duty[i]) next_fuel = fuel_corr[i];
    end
  end

  // PWM counter
  // The on-time follows the registered duty, so a change may land part way into a period
  logic [31:0] pwm_cnt;
  wire pwm_wrap = pwm_cnt == 32'(PWM_CYC - 1);
  wire [31:0] on_cyc = 32'((64'(PWM_CYC) * 64'(valve_duty)) / 64'(DUTY_FULL));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pwm_cnt <= 32'h0000_0000;
    else if (clk_en) pwm_cnt <= pwm_wrap ? 32'h0000_0000 : pwm_cnt + 32'h0000_0001;
  end

  // Read mux
  // Unmapped addresses read as zero; the tables are scanned in the default branch
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (bus.addr)
      REG_CTRL: next_rdata = {30'h0, ctrl};
      REG_TARGET: next_rdata = {16'h0, target};
      REG_FAST_TARGET: next_rdata = {16'h0, fast_target};
      REG_DECAY_TICKS: next_rdata = {16'h0, decay_ticks};
      REG_VALVE_CFG: next_rdata = {16'h0, valve_min, valve_max};
      REG_VALVE_TICKS: next_rdata = {16'h0, valve_ticks};
      REG_SPARK_CFG: next_rdata = {24'h0, spark_max};
      REG_SPARK_TICKS: next_rdata = {16'h0, spark_ticks};
      REG_STATUS: next_rdata = {eff_target, 13'h0, spark_on, valve_on, active};
      REG_OUTPUTS: next_rdata = {fuel_scale, spark_corr, valve_duty};
      default: begin
        for (int i = 0; i < TBL_N; i++) begin
          if (bus.addr == REG_VALVE_TBL + 8'(4 * i)) next_rdata = {{24{valve_tbl[i][7]}}, valve_tbl[i]};
          if (bus.addr == REG_SPARK_TBL + 8'(4 * i)) next_rdata = {{24{spark_tbl[i][7]}}, spark_tbl[i]};
        end
        for (int i = 0; i < FUEL_N; i++) begin
          if (bus.addr == REG_FUEL_DUTY + 8'(4 * i)) next_rdata = {24'h0, fuel_duty[i]};
          if (bus.addr == REG_FUEL_CORR + 8'(4 * i)) next_rdata = {16'h0, fuel_corr[i]};
        end
      end
    endcase
  end

  // Output registers
  // Read data stand for one cycle and then return to zero, so stale data never linger
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
      valve_low_n <= 1'b1;
      valve_duty <= '0;
      spark_corr <= 8'sh00;
      fuel_scale <= FUEL_UNITY;
    end else if (clk_en) begin
      rdata <= bus.rd ? next_rdata : 32'h0000_0000;
      valve_duty <= next_duty;
      spark_corr <= sacc[7:0];
      fuel_scale <= next_fuel;
      valve_low_n <= !(pwm_cnt < on_cyc);
    end
  end

  // Assertions
  // Valve trim stays at or under its positive authority, unless the limit was just lowered
  a_trim_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    vacc <= $signed({2'b00, valve_max}) || $past(vacc) > $signed({2'b00, valve_max}))
    else $error("valve trim over limit");
  // While trimming, the driven duty never sits under the floor
  a_duty_floor: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && valve_on && $stable(valve_on) |=> valve_duty >= $past(valve_min) || !$past(valve_on))
    else $error("duty under floor");
  // Valve trim only moves on its check interval
  a_hold_between: assert property (@(posedge sys_clk) disable iff (!rst_n)
    valve_on && !vdue && $past(valve_on) |=> $stable(vacc) || !valve_on)
    else $error("valve trim moved off interval");
  // A disabled valve trim is cleared
  a_off_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !valve_on |=> vacc == 0)
    else $error("trim kept while disabled");
  // A disabled spark trim is cleared
  a_spark_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !spark_on |=> sacc == 0)
    else $error("spark trim kept while disabled");
  // Each spark update lands inside plus or minus the degree limit
  a_spark_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && spark_on && sdue |=> sacc <= $signed({2'b00, $past(spark_max)}) &&
    sacc >= -$signed({2'b00, $past(spark_max)}))
    else $error("spark trim over limit");
  // Spark trim only moves on its own check interval
  a_spark_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    spark_on && !sdue |=> $stable(sacc))
    else $error("spark trim moved off interval");
  c_valve_update: cover property (@(posedge sys_clk) valve_on && vdue);
  c_spark_update: cover property (@(posedge sys_clk) spark_on && sdue);
  c_decay: cover property (@(posedge sys_clk) active && decay_due);
endmodule : isc_top

/* test/isc_valve_model.sv */
`timescale 1ns/1ns
// Idle valve as seen from its drive pin: measures switch-on time and period
module isc_valve_model (
  input wire logic sys_clk,
  input wire logic valve_low_n,
  output int low_cycles,
  output int period_cycles
);
  int low_cnt = 0; // Low samples in the running period
  int per_cnt = 0; // Samples since the last switch-on
  logic last_n = 1'b1; // Previous pin level
  // Report at each switch-on; the first report counts from the start of the run, not over a whole period
  always @(posedge sys_clk) begin
    last_n <= valve_low_n;
    if (last_n === 1'b1 && valve_low_n === 1'b0) begin
      low_cycles <= low_cnt;
      period_cycles <= per_cnt;
      low_cnt <= 1;
      per_cnt <= 1;
    end else begin
      low_cnt <= low_cnt + ((valve_low_n === 1'b0) ? 1 : 0);
      per_cnt <= per_cnt + 1;
    end
  end
endmodule : isc_valve_model

/* test/testbench.sv */
`timescale 1ns/1ns
// Self-checking bench for the idle speed regulator
module testbench;
  import isc_pkg::*;
  localparam int TICK = 10; // Shortened 10 ms tick
  localparam int PWM = 200; // Shortened period: one cycle per half percent
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  isc_engine_s engine = '{rpm: 16'h0352, throttle_ok: 1'b1, speed_ok: 1'b1, coolant_ok: 1'b1, warm_duty: 8'h5A};
  isc_bus_s bus = '0;
  logic [31:0] rdata;
  logic valve_low_n;
  logic [DUTY_W-1:0] valve_duty;
  logic signed [7:0] spark_corr;
  logic [15:0] fuel_scale;
  int low_cycles;
  int period_cycles;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int vt[7] = '{2, 1, 1, 0, -1, -1, -1}; // Valve entries, half percent, -150 first
  int st[7] = '{2, 1, 1, 0, -1, -1, -2}; // Spark entries, degrees
  int fd[5] = '{78, 81, 83, 85, 88}; // Fuel breakpoints, half percent
  int fc[5] = '{95, 97, 100, 105, 110}; // Fuel corrections, percent

  always #5 sys_clk = ~sys_clk;

  isc_top #(.PWM_CYC(PWM), .TICK_LEN(TICK)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .engine(engine), .bus(bus),
    .rdata(rdata), .valve_low_n(valve_low_n), .valve_duty(valve_duty), .spark_corr(spark_corr),
    .fuel_scale(fuel_scale));
  isc_valve_model valve (.sys_clk(sys_clk), .valve_low_n(valve_low_n), .low_cycles(low_cycles),
    .period_cycles(period_cycles));

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // Watchdog: the whole run needs well under 10000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe, launched right after an edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, and are taken there
  task rd_word(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_word

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_word(a, v);
    chk(what, exp, v);
  endtask : rd_chk

  // Drop an enabling condition for two cycles so that the next entry reloads the fast target
  task restart;
    @(posedge sys_clk);
    engine.speed_ok <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    engine.speed_ok <= 1'b1;
    @(posedge sys_clk);
  endtask : restart

  task wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  // Reset values, register read-back and an unmapped read
  task t_reset;
    wait_cyc(10);
    chk("rdata", 32'h0000_0000, rdata);
    chk("valve_low_n", 32'h0000_0001, {31'h0000_0000, valve_low_n});
    chk("duty", 32'h0000_0000, {24'h00_0000, valve_duty});
    chk("spark", 32'h0000_0000, {24'h00_0000, spark_corr});
    chk("fuel", 32'h0000_0064, {16'h0000, fuel_scale});
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1; // Released on a rising edge; the design adds two flops of its own
    wait_cyc(3);
    rd_chk("target", REG_TARGET, 32'h0000_03E8);
    rd_chk("unmapped", 8'hFC, 32'h0000_0000);
    wr(REG_TARGET, 32'h0000_03E8);
    wr(REG_FAST_TARGET, 32'h0000_03E8); // Equal targets keep the effective target fixed
    wr(REG_VALVE_CFG, 32'h0000_4E06); // Floor 39 %, authority 3 %
    wr(REG_VALVE_TICKS, 32'h0000_0002);
    wr(REG_SPARK_CFG, 32'h0000_0008);
    wr(REG_SPARK_TICKS, 32'h0000_0002);
    for (int i = 0; i < 7; i++) wr(REG_VALVE_TBL + 8'(4 * i), 32'(vt[i]));
    for (int i = 0; i < 7; i++) wr(REG_SPARK_TBL + 8'(4 * i), 32'(st[i]));
    for (int i = 0; i < 5; i++) wr(REG_FUEL_DUTY + 8'(4 * i), 32'(fd[i]));
    for (int i = 0; i < 5; i++) wr(REG_FUEL_CORR + 8'(4 * i), 32'(fc[i]));
    restart(); // The target has been decaying since reset; re-entry loads the new fast target
    rd_chk("entry target", REG_STATUS, 32'h03E8_0001);
    rd_chk("valve table", REG_VALVE_TBL + 8'h18, 32'hFFFF_FFFF);
  endtask : t_reset

  // Open loop: warm duty alone, fuel from the duty, 80 Hz drive scaled down
  task t_open_loop;
    logic [7:0] w[4];
    logic [15:0] f[4];
    w = '{8'h50, 8'h53, 8'h56, 8'h5A};
    f = '{16'h005F, 16'h0064, 16'h0069, 16'h006E};
    for (int i = 0; i < 4; i++) begin
      engine.warm_duty <= w[i];
      wait_cyc(60);
      chk("duty", {24'h00_0000, w[i]}, {24'h00_0000, valve_duty});
      chk("fuel", {16'h0000, f[i]}, {16'h0000, fuel_scale});
    end
    wait_cyc(500);
    chk("low time", 32'h0000_005A, 32'(low_cycles));
    chk("period", 32'h0000_00C8, 32'(period_cycles));
    chk("spark", 32'h0000_0000, {24'h00_0000, spark_corr});
  endtask : t_open_loop

  // Valve trim: step size, hold between checks, clamps, floor, enabling conditions
  task t_valve;
    int n;
    wr(REG_CTRL, 32'h0000_0001);
    engine.rpm <= 16'h03B6;
    n = 0;
    while (valve_duty === 8'h5A && n < 100) begin
      wait_cyc(1);
      n++;
    end
    chk("first step", 32'h0000_005B, {24'h00_0000, valve_duty});
    wait_cyc(15);
    chk("held", 32'h0000_005B, {24'h00_0000, valve_duty});
    engine.rpm <= 16'h0352;
    wait_cyc(400);
    chk("upper clamp", 32'h0000_0060, {24'h00_0000, valve_duty});
    chk("spark off", 32'h0000_0000, {24'h00_0000, spark_corr});
    engine.rpm <= 16'h0578;
    wait_cyc(400);
    chk("lower clamp", 32'h0000_0054, {24'h00_0000, valve_duty});
    wr(REG_VALVE_CFG, 32'h0000_5806);
    wait_cyc(60);
    chk("floor", 32'h0000_0058, {24'h00_0000, valve_duty});
    engine.coolant_ok <= 1'b0;
    wait_cyc(60);
    chk("cold revert", 32'h0000_005A, {24'h00_0000, valve_duty});
    engine.coolant_ok <= 1'b1;
    wr(REG_CTRL, 32'h0000_0000);
    wait_cyc(60);
    chk("disabled", 32'h0000_005A, {24'h00_0000, valve_duty});
  endtask : t_valve

  // Spark trim on its own enable, clamped both ways, cleared when off
  task t_spark;
    wr(REG_CTRL, 32'h0000_0002);
    engine.rpm <= 16'h0352;
    wait_cyc(400);
    chk("advance clamp", 32'h0000_0008, {24'h00_0000, spark_corr});
    chk("valve off", 32'h0000_005A, {24'h00_0000, valve_duty});
    engine.rpm <= 16'h0578;
    wait_cyc(400);
    chk("retard clamp", 32'h0000_00F8, {24'h00_0000, spark_corr});
    wr(REG_CTRL, 32'h0000_0000);
    wait_cyc(60);
    chk("spark cleared", 32'h0000_0000, {24'h00_0000, spark_corr});
  endtask : t_spark

  // Return to idle: fast target first, then 50 rpm down per decay interval to the normal target
  task t_decay;
    int n;
    logic [31:0] prev;
    logic [31:0] v;
    wr(REG_DECAY_TICKS, 32'h0000_0002);
    wr(REG_FAST_TARGET, 32'h0000_0514);
    restart();
    rd_chk("fast target", REG_STATUS, 32'h0514_0001);
    prev = 32'h0514_0001;
    for (int s = 0; s < 6; s++) begin
      n = 0;
      v = prev;
      while (v === prev && n < 40) begin
        rd_word(REG_STATUS, v);
        n++;
      end
      chk("target step", prev - 32'h0032_0000, v);
      prev = v;
    end
    wait_cyc(60);
    rd_chk("normal target", REG_STATUS, 32'h03E8_0001);
  endtask : t_decay

  initial begin
    t_reset();
    t_open_loop();
    t_valve();
    t_spark();
    t_decay();
    close_out();
  end
endmodule : testbench
